// [core/sdc_pkg.sv]
package sdc_pkg;

  // Conversion modes
  typedef enum logic [1:0] {
    SDC_MODE_SINGLE = 2'h0,
    SDC_MODE_MULTI = 2'h1,
    SDC_MODE_CONT = 2'h2,
    SDC_MODE_TURBO = 2'h3
  } sdc_mode_t;

  // Resolution codes
  typedef enum logic [1:0] {
    SDC_RES_8 = 2'h0,
    SDC_RES_12 = 2'h1,
    SDC_RES_16 = 2'h2,
    SDC_RES_20 = 2'h3
  } sdc_res_t;

  // Register word indexes
  localparam logic [3:0] SDC_REG_CTRL = 4'h0;
  localparam logic [3:0] SDC_REG_STAT = 4'h1;
  localparam logic [3:0] SDC_REG_RESULT = 4'h2;
  localparam logic [3:0] SDC_REG_IRQ_STAT = 4'h3;
  localparam logic [3:0] SDC_REG_IRQ_MASK = 4'h4;

  // Control field positions
  localparam int SDC_CTRL_START_BIT = 0;
  localparam int SDC_CTRL_MODE_LSB = 1;
  localparam int SDC_CTRL_RES_LSB = 3;
  localparam int SDC_CTRL_MUXSEL_LSB = 5;
  localparam int SDC_CTRL_STOP_BIT = 8;

  // Status field positions
  localparam int SDC_STAT_DONE_BIT = 0;
  localparam int SDC_STAT_BUSY_BIT = 1;
  localparam int SDC_STAT_VALID_BIT = 2;

  // Interrupt status bits
  localparam int SDC_IRQ_DONE_BIT = 0;
  localparam int SDC_IRQ_OVERRUN_BIT = 1;

  // Reset values
  localparam logic [1:0] SDC_MODE_RST = 2'h0;
  localparam logic [1:0] SDC_RES_RST = 2'h2;
  localparam logic [2:0] SDC_MUXSEL_RST = 3'h0;
  localparam logic [1:0] SDC_IRQ_RST = 2'h0;

  // Decimator pipeline depth: result valid after the fourth conversion
  localparam logic [2:0] SDC_PRIME_CONV = 3'h3;
  localparam logic [2:0] SDC_PIPE_DEPTH = 3'h4;

  // Sample rates per resolution, samples per second
  localparam int SDC_RATE_20_SPS = 187;
  localparam int SDC_RATE_16_SPS = 48000;
  localparam int SDC_RATE_12_SPS = 192000;
  localparam int SDC_RATE_8_SPS = 384000;
  localparam int SDC_CLK_HZ = 100000000;

  // Cycles per conversion, rounded up so the rate is never exceeded
  localparam int SDC_CYC_20 = (SDC_CLK_HZ + SDC_RATE_20_SPS - 1) / SDC_RATE_20_SPS;
  localparam int SDC_CYC_16 = (SDC_CLK_HZ + SDC_RATE_16_SPS - 1) / SDC_RATE_16_SPS;
  localparam int SDC_CYC_12 = (SDC_CLK_HZ + SDC_RATE_12_SPS - 1) / SDC_RATE_12_SPS;
  localparam int SDC_CYC_8 = (SDC_CLK_HZ + SDC_RATE_8_SPS - 1) / SDC_RATE_8_SPS;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sdc_bus_req_t;

endpackage : sdc_pkg

// [core/sdc_sequencer.sv]
// Added by the designer: strobed register access and the register offsets.
module sdc_sequencer
  import sdc_pkg::*;
#(
  parameter int CYC_20 = SDC_CYC_20,
  parameter int CYC_16 = SDC_CYC_16,
  parameter int CYC_12 = SDC_CYC_12,
  parameter int CYC_8 = SDC_CYC_8,
  parameter int DATA_W = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic conv_trigger_in,
  input wire logic [DATA_W-1:0] decim_data_in,
  output logic decim_reset_out,
  output logic conv_strobe_out,
  output logic [2:0] mux_sel_out,
  output logic result_ready_out,
  output logic irq_out
);

  typedef enum logic [3:0] {
    SDC_ST_STANDBY = 4'h1,
    SDC_ST_PRIME = 4'h2,
    SDC_ST_CONVERT = 4'h4,
    SDC_ST_HOLD = 4'h8
  } sdc_state_t;

  sdc_bus_req_t bus;
  sdc_state_t state_ff;
  sdc_state_t nxt_state;
  sdc_mode_t mode_ff;
  sdc_res_t res_ff;
  logic [2:0] mux_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_mask_ff;
  logic [DATA_W-1:0] result_ff;
  logic ready_ff;
  logic valid_ff;
  logic [2:0] conv_cnt_ff;
  logic [2:0] since_mux_ff;
  logic [31:0] tick_ff;
  logic trig_d_ff;
  logic conv_end;
  logic sw_start;
  logic hw_start;
  logic start_req;
  logic result_rd;
  logic result_evt;
  logic ctrl_wr;
  logic stop_req;
  logic mux_change;
  logic chain_mode;
  logic idle;
  logic irq_wr_hit;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [1:0] nxt_irq_stat;

  // Cycles per conversion for a resolution code
  // The 20-bit period needs about 20 bits; 32 leave room for faster clocks
  function automatic logic [31:0] period_of(sdc_res_t r);
    case (r)
      SDC_RES_20: period_of = 32'(CYC_20);
      SDC_RES_16: period_of = 32'(CYC_16);
      SDC_RES_12: period_of = 32'(CYC_12);
      SDC_RES_8: period_of = 32'(CYC_8);
      default: period_of = 32'(CYC_16);
    endcase
  endfunction : period_of

  // Register hit decodes; the bus struct is passed in so that a
  // continuous assignment re-evaluates when any bus field moves
  function automatic logic wr_hit(sdc_bus_req_t b, logic [3:0] idx);
    wr_hit = b.wr && (b.addr == idx);
  endfunction : wr_hit

  function automatic logic rd_hit(sdc_bus_req_t b, logic [3:0] idx);
    rd_hit = b.rd && (b.addr == idx);
  endfunction : rd_hit

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign ctrl_wr = wr_hit(bus, SDC_REG_CTRL);
  assign stop_req = ctrl_wr && bus.wdata[SDC_CTRL_STOP_BIT];
  assign mux_change = ctrl_wr && (bus.wdata[SDC_CTRL_MUXSEL_LSB +: 3] != mux_ff);
  assign sw_start = ctrl_wr && bus.wdata[SDC_CTRL_START_BIT];
  assign hw_start = conv_trigger_in && !trig_d_ff;
  assign start_req = sw_start || hw_start;
  assign result_rd = rd_hit(bus, SDC_REG_RESULT);
  assign chain_mode = (mode_ff != SDC_MODE_SINGLE);
  // Standby decode shared by config gating, start and busy status
  assign idle = (state_ff == SDC_ST_STANDBY);

  ////////////////////////////////////////////////////////////////////////////
  // Trigger edge detector; input is already synchronous to clk
  // Cleared to the idle low level, so reset never fakes an edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_d_ff <= 1'b0;
    end else begin
      trig_d_ff <= conv_trigger_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration; mode and resolution only change in standby to keep
  // a running sequence consistent
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff <= sdc_mode_t'(SDC_MODE_RST);
      res_ff <= sdc_res_t'(SDC_RES_RST);
      mux_ff <= SDC_MUXSEL_RST;
    end else if (ctrl_wr) begin
      if (idle) begin
        mode_ff <= sdc_mode_t'(bus.wdata[SDC_CTRL_MODE_LSB +: 2]);
        res_ff <= sdc_res_t'(bus.wdata[SDC_CTRL_RES_LSB +: 2]);
      end
      // Mux is taken at any time; the valid bit tells software when the
      // pipeline has flushed the old input
      mux_ff <= bus.wdata[SDC_CTRL_MUXSEL_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timer; one conv_end pulse per conversion period
  // Resolution only moves in standby, so a running count never
  // overshoots a period that was shortened under it
  // rate from resolution
  assign conv_end = (state_ff == SDC_ST_PRIME || state_ff == SDC_ST_CONVERT)
                    && (tick_ff == period_of(res_ff) - 32'h1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_ff <= 32'h0;
    end else if (state_ff == SDC_ST_STANDBY || state_ff == SDC_ST_HOLD || conv_end) begin
      tick_ff <= 32'h0;
    end else begin
      tick_ff <= tick_ff + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SDC_ST_STANDBY: begin
        if (start_req) begin
          nxt_state = SDC_ST_PRIME;
        end
      end
      SDC_ST_PRIME: begin
        if (conv_end && conv_cnt_ff == SDC_PRIME_CONV - 3'h1) begin
          nxt_state = SDC_ST_CONVERT;
        end
      end
      SDC_ST_CONVERT: begin
        if (conv_end) begin
          if (mode_ff == SDC_MODE_CONT) begin
            nxt_state = SDC_ST_CONVERT;
          // multi and turbo reprime per sample
          end else if (chain_mode) begin
            nxt_state = SDC_ST_PRIME;
          end else begin
            nxt_state = SDC_ST_HOLD;
          end
        end
      end
      SDC_ST_HOLD: begin
        // back to standby after transfer
        // A stop while holding leaves ready set until software reads
        if (result_rd || !ready_ff) begin
          nxt_state = SDC_ST_STANDBY;
        end
      end
      default: nxt_state = SDC_ST_STANDBY;
    endcase
    // Software stop leaves any running mode
    // Stop overrides every other move so software can always regain standby
    if (stop_req) begin
      nxt_state = SDC_ST_STANDBY;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= SDC_ST_STANDBY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priming conversion counter
  // Counts only priming strobes; cleared whenever the machine leaves priming
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_cnt_ff <= 3'h0;
    end else if (state_ff != SDC_ST_PRIME) begin
      conv_cnt_ff <= 3'h0;
    end else if (conv_end) begin
      conv_cnt_ff <= conv_cnt_ff + 3'h1;
    end
  end

  // Decimator reset before each primed sequence
  assign decim_reset_out = (idle && start_req)
                           || (state_ff == SDC_ST_CONVERT && conv_end && chain_mode
                               && mode_ff != SDC_MODE_CONT);
  assign conv_strobe_out = conv_end;
  assign mux_sel_out = mux_ff;
  assign result_evt = conv_end && (state_ff == SDC_ST_CONVERT);

  ////////////////////////////////////////////////////////////////////////////
  // Samples since the last mux change or decimator reset, saturating at pipe depth
  // invalid until fourth sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_mux_ff <= 3'h0;
    end else if (mux_change || decim_reset_out) begin
      since_mux_ff <= 3'h0;
    end else if (conv_end && since_mux_ff != SDC_PIPE_DEPTH) begin
      since_mux_ff <= since_mux_ff + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result word and its valid flag, written only by a finished conversion
  // invalid until fourth sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_ff <= '0;
      valid_ff <= 1'b0;
    end else if (result_evt) begin
      result_ff <= decim_data_in;
      valid_ff <= (since_mux_ff == SDC_PIPE_DEPTH - 3'h1) || (since_mux_ff == SDC_PIPE_DEPTH);
    end
  end

  // Ready flag; a new result wins over a read in the same cycle, so a
  // fresh word is never reported as already taken
  // hold ready until read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_ff <= 1'b0;
    end else if (result_evt) begin
      ready_ff <= 1'b1;
    end else if (result_rd) begin
      ready_ff <= 1'b0;
    end
  end

  // ready usable as irq or dma request
  assign result_ready_out = ready_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt mask, plain read and write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask_ff <= SDC_IRQ_RST;
    end else if (wr_hit(bus, SDC_REG_IRQ_MASK)) begin
      irq_mask_ff <= bus.wdata[1:0];
    end
  end

  // Interrupt events; overrun marks a result that replaced an unread one
  always_comb begin
    irq_set = 2'h0;
    irq_set[SDC_IRQ_DONE_BIT] = result_evt;
    irq_set[SDC_IRQ_OVERRUN_BIT] = result_evt && ready_ff && !result_rd;
  end

  // Write one to clear; set wins, so an event in the clear cycle is kept
  assign irq_wr_hit = wr_hit(bus, SDC_REG_IRQ_STAT);
  assign irq_clr = irq_wr_hit ? bus.wdata[1:0] : 2'h0;
  assign nxt_irq_stat = irq_set | (irq_stat_ff & ~irq_clr);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_ff <= SDC_IRQ_RST;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  assign irq_out = |(irq_stat_ff & irq_mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe, zero otherwise
  // Only a RESULT read has a side effect; it releases the ready flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= 32'h0;
      if (bus.rd) begin
        case (bus.addr)
          SDC_REG_CTRL: begin
            reg_rdata[SDC_CTRL_MODE_LSB +: 2] <= mode_ff;
            reg_rdata[SDC_CTRL_RES_LSB +: 2] <= res_ff;
            reg_rdata[SDC_CTRL_MUXSEL_LSB +: 3] <= mux_ff;
          end
          SDC_REG_STAT: begin
            reg_rdata[SDC_STAT_DONE_BIT] <= ready_ff;
            reg_rdata[SDC_STAT_BUSY_BIT] <= !idle;
            reg_rdata[SDC_STAT_VALID_BIT] <= valid_ff;
          end
          SDC_REG_RESULT: reg_rdata[DATA_W-1:0] <= result_ff;
          SDC_REG_IRQ_STAT: reg_rdata[1:0] <= irq_stat_ff;
          SDC_REG_IRQ_MASK: reg_rdata[1:0] <= irq_mask_ff;
          default: reg_rdata <= 32'h0;
        endcase
      end
    end
  end

endmodule : sdc_sequencer

// [verif/sdc_sequencer_properties.sv]
module sdc_sequencer_checker
  import sdc_pkg::*;
#(
  parameter int CYC_20 = SDC_CYC_20,
  parameter int CYC_16 = SDC_CYC_16,
  parameter int CYC_12 = SDC_CYC_12,
  parameter int CYC_8 = SDC_CYC_8,
  parameter int DATA_W = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic conv_trigger_in,
  input wire logic [DATA_W-1:0] decim_data_in,
  input wire logic decim_reset_out,
  input wire logic conv_strobe_out,
  input wire logic [2:0] mux_sel_out,
  input wire logic result_ready_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] since_ff;
  // Strobes since decimator reset, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_ff <= 3'h0;
    end else if (decim_reset_out) begin
      since_ff <= 3'h0;
    end else if (conv_strobe_out && since_ff != 3'h7) begin
      since_ff <= since_ff + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A result read that no new capture races
  sequence s_take;
    reg_rd && (reg_addr == SDC_REG_RESULT) && !conv_strobe_out;
  endsequence
  // Shortest legal quiet stretch after a strobe
  sequence s_gap;
    !conv_strobe_out [*4];
  endsequence
  rdata_idle_a: assert property (
    reg_rdata != 32'h0 |-> $past(reg_rd)) else $error("read data outside slot");
  ready_hold_a: assert property (
    result_ready_out && !(reg_rd && reg_addr == SDC_REG_RESULT) |=> result_ready_out)
    else $error("ready fell unread");
  ready_drop_a: assert property (
    s_take |=> !result_ready_out) else $error("ready kept after read");
  ready_cause_a: assert property (
    $rose(result_ready_out) |-> $past(conv_strobe_out)) else $error("ready without strobe");
  prime_count_a: assert property (
    $rose(result_ready_out) |-> $past(since_ff) >= 3'h3) else $error("result before priming");
  strobe_gap_a: assert property (
    conv_strobe_out |=> s_gap) else $error("strobes too close");
  dreset_pulse_a: assert property (
    decim_reset_out |=> !decim_reset_out [*3]) else $error("reset pulse too long");
  mux_hold_a: assert property (
    $changed(mux_sel_out) |-> $past(reg_wr && reg_addr == SDC_REG_CTRL))
    else $error("mux moved on its own");
  irq_cause_a: assert property (
    $rose(irq_out) |-> $past(reg_wr || conv_strobe_out)) else $error("irq without cause");
endmodule : sdc_sequencer_checker

bind sdc_sequencer sdc_sequencer_checker #(.CYC_20(CYC_20), .CYC_16(CYC_16),
  .CYC_12(CYC_12), .CYC_8(CYC_8), .DATA_W(DATA_W)) u_chk (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .conv_trigger_in(conv_trigger_in), .decim_data_in(decim_data_in),
  .decim_reset_out(decim_reset_out), .conv_strobe_out(conv_strobe_out),
  .mux_sel_out(mux_sel_out), .result_ready_out(result_ready_out), .irq_out(irq_out));

// [verif/sdc_decim_model.sv]
module sdc_decim_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic decim_reset_out,
  input wire logic conv_strobe_out,
  input wire logic [19:0] pat,
  output logic [19:0] decim_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] cnt_ff;
  // Samples since reset, so stale history shows in the word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 20'h0;
    end else if (decim_reset_out) begin
      cnt_ff <= 20'h0;
    end else if (conv_strobe_out) begin
      cnt_ff <= cnt_ff + 20'h1;
    end
  end
  assign decim_data_in = pat ^ cnt_ff;
endmodule : sdc_decim_model

// [verif/sdc_sequencer_tb.sv]
module sdc_sequencer_tb
  import sdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER[4] = '{6, 7, 8, 9};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic conv_trigger_in = 1'b0;
  logic [19:0] pat = 20'h0;
  logic [31:0] reg_rdata;
  logic [19:0] decim_data_in;
  logic decim_reset_out;
  logic conv_strobe_out;
  logic result_ready_out;
  logic irq_out;
  logic [2:0] mux_sel_out;
  logic [31:0] exp_q[$];
  logic rd_d = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  int n_strobe = 0;
  int cyc = 0;
  int last = 0;
  int gap = 0;
  int seed = 32'h06f77253;
  always #5 clk = ~clk;
  sdc_sequencer #(.CYC_20(9), .CYC_16(8), .CYC_12(7), .CYC_8(6)) dut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_trigger_in(conv_trigger_in), .decim_data_in(decim_data_in),
    .decim_reset_out(decim_reset_out), .conv_strobe_out(conv_strobe_out),
    .mux_sel_out(mux_sel_out), .result_ready_out(result_ready_out), .irq_out(irq_out));
  sdc_decim_model u_decim (.clk(clk), .rst(rst), .decim_reset_out(decim_reset_out),
    .conv_strobe_out(conv_strobe_out), .pat(pat), .decim_data_in(decim_data_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
    n_compared++;
    if (seen !== expd) begin
      err_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, expd);
    end
  endtask : chk
  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // Read slot and strobe spacing, sampled mid-cycle to dodge edge races
  always @(negedge clk) begin
    if (rd_d) begin
      chk(reg_rdata, exp_q.pop_front());
    end
    rd_d = reg_rd;
    cyc++;
    if (conv_strobe_out) begin
      n_strobe++;
      gap = cyc - last;
      last = cyc;
    end
  end
  // Hang guard
  initial begin
    #100000;
    err_count++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic wait_rdy(input int lim);
    int i;
    i = 0;
    while (result_ready_out !== 1'b1 && i < lim) begin
      @(negedge clk);
      i++;
    end
    if (i == lim) chk(32'h0, 32'h1);
    @(posedge clk);
  endtask : wait_rdy
  function automatic logic [31:0] ctrl(input logic [1:0] m, input logic [1:0] r, input logic s);
    return {27'h0, r, m, s};
  endfunction : ctrl
  // Single shot; odd resolutions start from the pin, long pulse plus a retrigger
  task automatic one_shot(input logic [1:0] r);
    int s0;
    pat <= 20'($random(seed));
    wr(SDC_REG_CTRL, ctrl(SDC_MODE_SINGLE, r, 1'b0));
    s0 = n_strobe;
    if (r[0]) begin
      conv_trigger_in <= 1'b1;
      repeat (3) @(posedge clk);
      conv_trigger_in <= 1'b0;
      repeat (2 * PER[r]) @(posedge clk);
      conv_trigger_in <= 1'b1;
      @(posedge clk);
      conv_trigger_in <= 1'b0;
    end else begin
      wr(SDC_REG_CTRL, ctrl(SDC_MODE_SINGLE, r, 1'b1));
      if (r == 2'h2) begin
        repeat (PER[r]) @(posedge clk);
        wr(SDC_REG_CTRL, ctrl(SDC_MODE_SINGLE, r, 1'b0) | 32'h20);
        chk({29'h0, mux_sel_out}, 32'h1);
      end
    end
    wait_rdy(6 * PER[r]);
    chk(32'(n_strobe - s0), 32'h4);
    chk(32'(gap), 32'(PER[r]));
    if (r == 2'h2) rd(SDC_REG_STAT, 32'h3);
    rd(SDC_REG_RESULT, {12'h0, pat ^ 20'h3});
    chk({31'h0, result_ready_out}, 32'h0);
    repeat (3 * PER[r]) @(posedge clk);
    chk(32'(n_strobe - s0), 32'h4);
    $display("Test single %0d done", r);
  endtask : one_shot
  // Chained mode; first result left unread to force an overrun
  task automatic chain(input logic [1:0] m);
    int s0;
    wr(SDC_REG_CTRL, ctrl(m, SDC_RES_8, 1'b0));
    s0 = n_strobe;
    wr(SDC_REG_CTRL, ctrl(m, SDC_RES_8, 1'b1));
    wait_rdy(6 * PER[0]);
    repeat (4 * PER[0] + 2) @(posedge clk);
    chk(32'(n_strobe - s0), 32'h8);
    rd(SDC_REG_RESULT, {12'h0, pat ^ 20'h3});
    rd(SDC_REG_IRQ_STAT, 32'h3);
    wr(SDC_REG_IRQ_STAT, 32'h3);
    wr(SDC_REG_CTRL, 32'h100);
    rd(SDC_REG_IRQ_STAT, 32'h0);
    $display("Test chain %0d done", m);
  endtask : chain
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(SDC_REG_CTRL, 32'h10);
    rd(SDC_REG_IRQ_MASK, 32'h0);
    rd(4'hF, 32'h0);
    for (int r = 0; r < 4; r++) begin
      one_shot(2'(r));
    end
    rd(SDC_REG_IRQ_STAT, 32'h1);
    chk({31'h0, irq_out}, 32'h0);
    wr(SDC_REG_IRQ_MASK, 32'h1);
    chk({31'h0, irq_out}, 32'h1);
    wr(SDC_REG_IRQ_STAT, 32'h1);
    chk({31'h0, irq_out}, 32'h0);
    $display("Test irq done");
    chain(SDC_MODE_MULTI);
    chain(SDC_MODE_TURBO);
    // Continuous: trigger idle, mux untouched throughout
    // mux held fixed
    wr(SDC_REG_CTRL, ctrl(SDC_MODE_CONT, SDC_RES_16, 1'b1));
    for (int k = 0; k < 3; k++) begin
      wait_rdy(6 * PER[2]);
      chk(32'(gap), 32'(PER[2]));
      if (k == 0) rd(SDC_REG_STAT, 32'h7);
      rd(SDC_REG_RESULT, {12'h0, pat ^ 20'(3 + k)});
    end
    wr(SDC_REG_CTRL, 32'h100);
    $display("Test continuous done");
    test_done();
  end
endmodule : sdc_sequencer_tb
